// *** rmln_pkg.sv ***
package rmln_pkg;

  // Register byte offsets
  localparam logic [3:0] REG_MODE_OFS   = 4'h0;
  localparam logic [3:0] REG_PLL_OFS    = 4'h4;
  localparam logic [3:0] REG_IRQCFG_OFS = 4'h8;
  localparam logic [3:0] REG_STATUS_OFS = 4'hC;

  // Field positions
  localparam int MODE_LSB       = 0;
  localparam int PLL_ON_POS     = 0;
  localparam int CFG_EDGE_A_POS = 0;
  localparam int CFG_EDGE_B_POS = 1;
  localparam int CFG_STOP_POS   = 2;
  localparam int ST_PINS_POS    = 0;
  localparam int ST_STOP_POS    = 3;
  localparam int ST_CLKON_POS   = 4;

  // Reset values
  localparam logic [2:0]  MODE_RST   = 3'h0;
  localparam logic        PLL_RST    = 1'b0;
  localparam logic [2:0]  CFG_RST    = 3'h0;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

  // Timing
  localparam int CLK_MHZ         = 250;
  localparam int HANDOVER_NS     = 16;
  localparam int HANDOVER_CYC    = (HANDOVER_NS * CLK_MHZ + 999) / 1000;
  localparam int STABLE_US       = 20;
  localparam int STABLE_CYC      = STABLE_US * CLK_MHZ;
  localparam logic [1:0] NMI_PRIO = 2'h3;

  typedef enum {
    ST_RESET,
    ST_HANDOVER,
    ST_RUN
  } rmln_phase_t;

  typedef struct packed {
    logic first;
    logic second;
    logic third;
  } rmln_mode_pins_t;

  typedef struct packed {
    logic       req_first;
    logic       req_second;
    logic       nmi;
    logic [1:0] nmi_prio;
  } rmln_irq_t;

endpackage : rmln_pkg

// *** rmln_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module rmln_sync
  import rmln_pkg::*;
#(
  parameter int WIDTH = 5
) (
  input  wire logic             ref_clk_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  if (WIDTH < 1) begin : g_bad_width
    $error("rmln_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // No reset: pins are sampled continuously so levels are valid at release
  always_ff @(posedge ref_clk_i) begin
    meta_ff <= async_i;
    sync_ff <= meta_ff;
  end

  assign sync_o = sync_ff;

endmodule : rmln_sync
`default_nettype wire

// *** rmln_edge_req.sv ***
`timescale 1ns/1ps
`default_nettype none
module rmln_edge_req
  import rmln_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic enable_i,
  input  wire logic edge_mode_i,
  input  wire logic level_n_i,
  output logic      req_o
);

  logic prev_ff;
  logic nxt_prev;
  logic req_ff;
  logic nxt_req;

  always_comb begin
    nxt_prev = level_n_i;
    nxt_req  = 1'b0;
    if (enable_i) begin
      if (edge_mode_i) begin
        nxt_req = prev_ff & ~level_n_i;
      end else begin
        nxt_req = ~level_n_i;
      end
    end
  end

  // Prev held high in reset, so a pin low at release gives an edge if enable_i is high
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      prev_ff <= 1'b1;
      req_ff  <= 1'b0;
    end else begin
      prev_ff <= nxt_prev;
      req_ff  <= nxt_req;
    end
  end

  assign req_o = req_ff;

endmodule : rmln_edge_req
`default_nettype wire

// *** rmln_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Hold reset state; three pins select mode
// - Latch three mode pins at reset release
// - Copy pll strap into pll on bit
// - Third pin becomes nmi after delay
// - Software may overwrite latched mode
// - Nmi fires on falling edge only
// - Nmi priority three, never masked
// - Synchronise pin requests to clock
// - Reset returns pins to mode select
// - First, second pins become requests A, B
// - Requests A, B level or edge selectable
// - Stop mode wake by request A
module rmln_top
  import rmln_pkg::*;
#(
  parameter int STABLE_CYCLES = STABLE_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        mode_select_first_i,
  input  wire logic        mode_select_second_i,
  input  wire logic        mode_select_third_i,
  input  wire logic        pll_strap_pin_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic [2:0]       op_mode_o,
  output logic             pll_on_bit_o,
  output logic             in_reset_o,
  output logic             external_request_first_o,
  output logic             external_request_second_o,
  output logic             nmi_req_o,
  output logic [1:0]       nmi_prio_o,
  output logic             core_clk_en_o
);

  // Refused at elaboration: a zero count would never end a wake
  if (STABLE_CYCLES < 1) begin : g_bad_stable
    $error("rmln_top: STABLE_CYCLES must be at least 1");
  end
  if (HANDOVER_CYC < 1) begin : g_bad_handover
    $error("rmln_top: HANDOVER_CYC must be at least 1");
  end

  localparam int HCW = $clog2(HANDOVER_CYC + 1);
  localparam int SCW = $clog2(STABLE_CYCLES + 1);

  // Pin synchroniser
  logic [3:0]      pins_sync;
  rmln_mode_pins_t pins;
  logic            strap_s;

  rmln_sync #(
    .WIDTH (4)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .async_i   ({pll_strap_pin_i, mode_select_first_i, mode_select_second_i, mode_select_third_i}),
    .sync_o    (pins_sync)
  );

  assign strap_s = pins_sync[3];
  assign pins    = rmln_mode_pins_t'(pins_sync[2:0]);

  // Phase control
  rmln_phase_t     phase_ff;
  rmln_phase_t     nxt_phase;
  logic [HCW-1:0]  hcnt_ff;
  logic [HCW-1:0]  nxt_hcnt;
  logic [2:0]      mode_ff;
  logic [2:0]      nxt_mode;
  logic            pll_ff;
  logic            nxt_pll;
  logic            wr_mode;
  logic            wr_pll;

  always_comb begin
    nxt_phase = phase_ff;
    nxt_hcnt  = hcnt_ff;
    nxt_mode  = mode_ff;
    nxt_pll   = pll_ff;
    unique case (phase_ff)
      ST_RESET: begin
        // First cycle out of reset: latch pins and strap
        nxt_mode  = {pins.third, pins.second, pins.first};
        nxt_pll   = strap_s;
        nxt_hcnt  = '0;
        nxt_phase = ST_HANDOVER;
      end
      ST_HANDOVER: begin
        nxt_hcnt = hcnt_ff + HCW'(1);
        if (hcnt_ff == HCW'(HANDOVER_CYC - 1)) begin
          nxt_phase = ST_RUN;
        end
      end
      ST_RUN: begin
        nxt_phase = ST_RUN;
      end
    endcase
    if (phase_ff != ST_RESET) begin
      if (wr_mode) begin
        nxt_mode = avs_writedata_i[MODE_LSB +: 3];
      end
      if (wr_pll) begin
        nxt_pll = avs_writedata_i[PLL_ON_POS];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      phase_ff <= ST_RESET;
      hcnt_ff  <= '0;
      mode_ff  <= MODE_RST;
      pll_ff   <= PLL_RST;
    end else begin
      phase_ff <= nxt_phase;
      hcnt_ff  <= nxt_hcnt;
      mode_ff  <= nxt_mode;
      pll_ff   <= nxt_pll;
    end
  end

  logic irq_on;
  assign irq_on = (phase_ff == ST_RUN);

  // Interrupt configuration and stop mode
  logic [2:0]     cfg_ff;
  logic [2:0]     nxt_cfg;
  logic           stop_ff;
  logic           nxt_stop;
  logic           clkon_ff;
  logic           nxt_clkon;
  logic [SCW-1:0] scnt_ff;
  logic [SCW-1:0] nxt_scnt;
  logic           wr_cfg;
  rmln_irq_t      irq;

  rmln_edge_req u_req_first (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .enable_i    (irq_on),
    .edge_mode_i (cfg_ff[CFG_EDGE_A_POS]),
    .level_n_i   (pins.first),
    .req_o       (irq.req_first)
  );

  rmln_edge_req u_req_second (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .enable_i    (irq_on),
    .edge_mode_i (cfg_ff[CFG_EDGE_B_POS]),
    .level_n_i   (pins.second),
    .req_o       (irq.req_second)
  );

  // Edge mode tied on: nmi never level sensitive
  rmln_edge_req u_req_nmi (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .enable_i    (irq_on),
    .edge_mode_i (1'b1),
    .level_n_i   (pins.third),
    .req_o       (irq.nmi)
  );

  assign irq.nmi_prio = NMI_PRIO;

  always_comb begin
    nxt_cfg   = cfg_ff;
    nxt_stop  = stop_ff;
    nxt_clkon = clkon_ff;
    nxt_scnt  = scnt_ff;
    // Wake runs the stabilisation count before clocks return
    if (stop_ff) begin
      if (scnt_ff != '0) begin
        nxt_scnt = scnt_ff - SCW'(1);
        if (scnt_ff == SCW'(1)) begin
          nxt_stop  = 1'b0;
          nxt_clkon = 1'b1;
        end
      end else if (irq_on && !pins.first) begin
        nxt_scnt = SCW'(STABLE_CYCLES);
      end
    end
    // Last, so a stop request beats a wake ending in the same cycle
    if (wr_cfg) begin
      nxt_cfg = avs_writedata_i[2:0];
      if (avs_writedata_i[CFG_STOP_POS] && irq_on) begin
        nxt_stop  = 1'b1;
        nxt_clkon = 1'b0;
        nxt_scnt  = '0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cfg_ff   <= CFG_RST;
      stop_ff  <= 1'b0;
      clkon_ff <= 1'b1;
      scnt_ff  <= '0;
    end else begin
      cfg_ff   <= nxt_cfg;
      stop_ff  <= nxt_stop;
      clkon_ff <= nxt_clkon;
      scnt_ff  <= nxt_scnt;
    end
  end

  // Avalon slave: one wait cycle, answer on second cycle
  logic        ack_ff;
  logic        nxt_ack;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        req_any;
  logic        lane0;

  assign req_any = (avs_read_i || avs_write_i) && !ack_ff;
  assign lane0   = avs_byteenable_i[0];
  assign wr_mode = avs_write_i && ack_ff && lane0 && (avs_address_i == REG_MODE_OFS);
  assign wr_pll  = avs_write_i && ack_ff && lane0 && (avs_address_i == REG_PLL_OFS);
  assign wr_cfg  = avs_write_i && ack_ff && lane0 && (avs_address_i == REG_IRQCFG_OFS);

  always_comb begin
    nxt_ack   = req_any;
    nxt_rdata = rdata_ff;
    if (req_any && avs_read_i) begin
      nxt_rdata = UNMAPPED_RD;
      unique case (avs_address_i)
        REG_MODE_OFS:   nxt_rdata[MODE_LSB +: 3] = mode_ff;
        REG_PLL_OFS:    nxt_rdata[PLL_ON_POS] = pll_ff;
        REG_IRQCFG_OFS: nxt_rdata[2:0] = cfg_ff;
        REG_STATUS_OFS: begin
          nxt_rdata[ST_PINS_POS +: 3] = {pins.third, pins.second, pins.first};
          nxt_rdata[ST_STOP_POS]      = stop_ff;
          nxt_rdata[ST_CLKON_POS]     = clkon_ff;
        end
        default: nxt_rdata = UNMAPPED_RD;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ack_ff   <= 1'b0;
      rdata_ff <= UNMAPPED_RD;
    end else begin
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  assign avs_waitrequest_o         = (avs_read_i || avs_write_i) && !ack_ff;
  assign avs_readdata_o            = rdata_ff;
  assign op_mode_o                 = mode_ff;
  assign pll_on_bit_o              = pll_ff;
  assign in_reset_o                = (phase_ff == ST_RESET);
  assign external_request_first_o  = irq.req_first;
  assign external_request_second_o = irq.req_second;
  assign nmi_req_o                 = irq.nmi;
  assign nmi_prio_o                = irq.nmi_prio;
  assign core_clk_en_o             = clkon_ff;

endmodule : rmln_top
`default_nettype wire

// *** rmln_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module rmln_props
  import rmln_pkg::*;
(
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic       mode_select_third_i,
  input wire logic       avs_read_i,
  input wire logic       avs_write_i,
  input wire logic       avs_waitrequest_o,
  input wire logic [2:0] op_mode_o,
  input wire logic       in_reset_o,
  input wire logic       nmi_req_o,
  input wire logic [1:0] nmi_prio_o,
  input wire logic       core_clk_en_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req_waiting;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_settled;
    !in_reset_o && $past(in_reset_o) == 1'b0 && !avs_write_i && $past(avs_write_i) == 1'b0;
  endsequence

  a_prio_three: assert property (nmi_prio_o == NMI_PRIO) else $error("nmi priority wrong");
  // Reset checks must not be disabled by the reset they watch
  a_reset_hold: assert property (disable iff (1'b0) rst_i |=> in_reset_o && op_mode_o == MODE_RST && !nmi_req_o)
    else $error("reset state not held");
  a_reset_quiet: assert property (in_reset_o |-> !nmi_req_o) else $error("nmi during reset");
  a_nmi_single: assert property (nmi_req_o |=> !nmi_req_o) else $error("nmi pulse too long");
  a_nmi_cause: assert property (nmi_req_o |-> !$past(mode_select_third_i, 3)) else $error("nmi without low pin");
  a_handover_quiet: assert property ($fell(in_reset_o) |-> !nmi_req_o [*3]) else $error("nmi in handover");
  a_wait_one: assert property (s_req_waiting |=> !avs_waitrequest_o) else $error("no answer in one wait");
  a_wait_first: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("missing wait state");
  a_mode_hold: assert property (s_settled |-> $stable(op_mode_o)) else $error("mode moved without write");
  a_clk_reset: assert property (disable iff (1'b0) rst_i |=> core_clk_en_o) else $error("clock gated in reset");
endmodule : rmln_props

bind rmln_top rmln_props rmln_props_i (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .mode_select_third_i(mode_select_third_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .op_mode_o(op_mode_o), .in_reset_o(in_reset_o), .nmi_req_o(nmi_req_o),
  .nmi_prio_o(nmi_prio_o), .core_clk_en_o(core_clk_en_o)
);
`default_nettype wire

// *** rmln_board.sv ***
`timescale 1ns/1ps
`default_nettype none
// Board reset and pin source; pins only move just after an edge
module rmln_board
  import rmln_pkg::*;
(
  input  wire logic            ref_clk_i,
  input  wire logic            rst_cmd_i,
  input  wire rmln_mode_pins_t pins_cmd_i,
  input  wire logic            strap_cmd_i,
  output var  rmln_mode_pins_t pins_o,
  output var  logic            rst_o,
  output var  logic            strap_o
);
  initial begin
    rst_o   = 1'b1;
    pins_o  = '1;
    strap_o = 1'b0;
  end
  always @(posedge ref_clk_i) begin
    rst_o   <= rst_cmd_i;
    pins_o  <= pins_cmd_i;
    strap_o <= strap_cmd_i;
  end
endmodule : rmln_board
`default_nettype wire

// *** rmln_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module rmln_top_bench
  import rmln_pkg::*;
;
  logic            ref_clk_i = 1'b0;
  logic            rst_cmd   = 1'b1;
  logic            strap_cmd = 1'b0;
  logic            read      = 1'b0;
  logic            write     = 1'b0;
  logic [3:0]      addr      = 4'h0;
  logic [3:0]      be        = 4'h0;
  logic [31:0]     wdata     = 32'h0000_0000;
  rmln_mode_pins_t pins_cmd  = '1;
  rmln_mode_pins_t pins;
  logic            rst, strap, wreq, pll, in_rst, req_a, req_b, nmi, clk_en;
  logic [31:0]     rdata, q;
  logic [2:0]      mode;
  logic [1:0]      prio;
  int              num_errors = 0, n_compared = 0, n_nmi = 0, n_a = 0, seed = 32'hcbbe;

  always #2 ref_clk_i = ~ref_clk_i;

  rmln_board rmln_board_i (.ref_clk_i(ref_clk_i), .rst_cmd_i(rst_cmd), .pins_cmd_i(pins_cmd),
    .strap_cmd_i(strap_cmd), .pins_o(pins), .rst_o(rst), .strap_o(strap));

  // Short settle count keeps the wake test brief
  localparam int SETTLE = 8;
  rmln_top #(.STABLE_CYCLES(SETTLE)) rmln_top_i (.ref_clk_i(ref_clk_i), .rst_i(rst),
    .mode_select_first_i(pins.first), .mode_select_second_i(pins.second),
    .mode_select_third_i(pins.third), .pll_strap_pin_i(strap), .avs_address_i(addr),
    .avs_read_i(read), .avs_write_i(write), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .op_mode_o(mode), .pll_on_bit_o(pll),
    .in_reset_o(in_rst), .external_request_first_o(req_a), .external_request_second_o(req_b),
    .nmi_req_o(nmi), .nmi_prio_o(prio), .core_clk_en_o(clk_en));

  always @(posedge ref_clk_i) begin
    if (nmi === 1'b1) n_nmi++;
    if (req_a === 1'b1) n_a++;
  end

  function automatic logic [2:0] mode_of(input rmln_mode_pins_t p);
    return {p.third, p.second, p.first};
  endfunction : mode_of

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : tick

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    int k;
    k = 0;
    @(posedge ref_clk_i);
    read  <= !w;
    write <= w;
    addr  <= a;
    wdata <= d;
    be    <= b;
    do begin @(posedge ref_clk_i); k++; end while (wreq !== 1'b0 && k < 40);
    if (k >= 40) num_errors++;
    q = rdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic do_reset(input rmln_mode_pins_t p);
    rst_cmd   <= 1'b1;
    pins_cmd  <= ~p;
    strap_cmd <= 1'($random(seed));
    tick(4);
    pins_cmd <= p;
    tick(8);
    `CHK("in_reset", 1'b1, in_rst)
    rst_cmd <= 1'b0;
    tick(8);
    `CHK("mode", mode_of(p), mode)
    `CHK("pll", strap_cmd, pll)
    `CHK("in_reset", 1'b0, in_rst)
    `CHK("prio", NMI_PRIO, prio)
  endtask : do_reset

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  initial begin
    logic [2:0] m;
    int k;
    for (int i = 0; i < 8; i++) do_reset(rmln_mode_pins_t'(i));
    $display("reset test done");
    repeat (12) begin
      m = 3'($random(seed));
      bus(1'b1, REG_MODE_OFS, {29'h0, m}, 4'hf);
      bus(1'b1, REG_MODE_OFS, {29'h0, ~m}, 4'h0);
      bus(1'b0, REG_MODE_OFS, 32'h0000_0000, 4'hf);
      `CHK("mode rd", {29'h0, m}, q)
      bus(1'b1, REG_PLL_OFS, {31'h0, m[1]}, 4'hf);
      bus(1'b0, REG_PLL_OFS, 32'h0000_0000, 4'hf);
      `CHK("pll rd", {31'h0, m[1]}, q)
      `CHK("pll out", m[1], pll)
    end
    bus(1'b0, 4'h2, 32'h0000_0000, 4'hf);
    `CHK("unmapped", UNMAPPED_RD, q)
    bus(1'b0, REG_STATUS_OFS, 32'h0000_0000, 4'hf);
    `CHK("status", (32'h0000_0007 << ST_PINS_POS) | (32'h0000_0001 << ST_CLKON_POS), q)
    $display("bus test done");
    n_nmi = 0;
    pins_cmd.third <= 1'b0;
    tick(12);
    `CHK("nmi count", 1, n_nmi)
    pins_cmd.third <= 1'b1;
    $display("nmi test done");
    for (int e = 0; e < 2; e++) begin
      bus(1'b1, REG_IRQCFG_OFS, {30'h0, e[0], e[0]}, 4'hf);
      n_a = 0;
      pins_cmd.first  <= 1'b0;
      pins_cmd.second <= 1'b0;
      tick(10);
      `CHK("req b", e == 0, req_b)
      `CHK("req a count", e == 0, n_a > 1)
      pins_cmd.first  <= 1'b1;
      pins_cmd.second <= 1'b1;
      tick(4);
    end
    $display("request test done");
    bus(1'b1, REG_IRQCFG_OFS, 32'h0000_0004, 4'hf);
    tick(3);
    `CHK("clk gated", 1'b0, clk_en)
    bus(1'b0, REG_STATUS_OFS, 32'h0000_0000, 4'hf);
    `CHK("status stop", (32'h0000_0007 << ST_PINS_POS) | (32'h0000_0001 << ST_STOP_POS), q)
    pins_cmd.first <= 1'b0;
    k = 0;
    while (clk_en !== 1'b1 && k < 40) begin tick(1); k++; end
    `CHK("clk wake", 1'b1, clk_en)
    `CHK("wake delay", 1'b1, k > SETTLE)
    $display("stop test done");
    wrap_up;
  end

  // Tests need about 420 cycles; the 20000-cycle limit is ample
  initial begin
    #80000;
    num_errors++;
    wrap_up;
  end
endmodule : rmln_top_bench
`default_nettype wire
